/* File: include/branch_on_overflow_defs.vh */
`ifndef BRANCH_ON_OVERFLOW_DEFS_VH
`define BRANCH_ON_OVERFLOW_DEFS_VH
// opcode upper byte of the overflow branch
`define BOVF_OPCODE_HI 8'he4
// opcode field positions
`define BOVF_OPC_MSB 15
`define BOVF_OPC_LSB 8
`define BOVF_OFS_MSB 7
`define BOVF_OFS_LSB 0
// quarter phase codes
`define BOVF_Q1 2'h0
`define BOVF_Q2 2'h1
`define BOVF_Q3 2'h2
`define BOVF_Q4 2'h3
// reset values
`define BOVF_PC_RESET 21'h000000
`define BOVF_PHASE_RESET 2'h0
// ref_clk cycles per quarter phase
`define BOVF_Q_DIV 4
`endif

/* File: hdl/quarter_phase_gen.v */
`timescale 1ns/1ps
`include "branch_on_overflow_defs.vh"
module quarter_phase_gen #(
   parameter DIV = `BOVF_Q_DIV
)
(
   input wire ref_clk,
   input wire rstn,
   output reg q_en_r,
   output reg [1:0] q_phase_r
);
   reg [7:0] div_cnt_r;
   // q_en_r pulses once per quarter; q_phase_r names the quarter just ending
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         div_cnt_r <= 8'h00;
         q_en_r <= 1'b0;
         q_phase_r <= `BOVF_PHASE_RESET;
      end
      else
      begin
         q_en_r <= 1'b0;
         if (div_cnt_r == DIV[7:0] - 8'h01)
         begin
            div_cnt_r <= 8'h00;
            q_en_r <= 1'b1;
         end
         else
            div_cnt_r <= div_cnt_r + 8'h01;
         if (q_en_r)
            q_phase_r <= q_phase_r + 2'h1;
      end
   end
endmodule // quarter_phase_gen

/* File: hdl/branch_on_overflow.v */
// Functional notes
// RQ1: opcode upper byte e4 is the overflow branch; taken only if overflow is 1; flags untouched.
// RQ2: low opcode byte is a signed offset -128..127, doubled before use.
// RQ3: taken branch loads the program counter with counter plus doubled offset.
// RQ4: base is the counter already past the branch word: target = address+2+2n.
// RQ5: taken lasts two cycles, counter written in Q4 of cycle one; untaken one cycle.
`timescale 1ns/1ps
`include "branch_on_overflow_defs.vh"
module branch_on_overflow #(
   parameter PC_W = 21,
   parameter DIV = `BOVF_Q_DIV
)
(
   input wire ref_clk,
   input wire rstn,
   input wire instr_valid,
   input wire [15:0] instr_word,
   input wire [PC_W-1:0] pc_incr,
   input wire ovf_flag,
   output reg pc_we_r,
   output reg [PC_W-1:0] pc_new_r,
   output reg busy_r,
   output reg done_r,
   output reg [1:0] q_phase_out_r
);
   // sequencer states
   localparam S_IDLE = 2'h0;
   localparam S_EXEC = 2'h1;
   localparam S_STALL = 2'h2;

   // quarter strobe and quarter number from the divider
   wire q_en;
   wire [1:0] q_phase;

   // sequencer state and its next value
   reg [1:0] state_r;
   reg [1:0] state_nxt;

   // fields captured at decode, held for the rest of the branch
   reg take_r;
   reg take_nxt;
   reg [7:0] ofs_r;
   reg [7:0] ofs_nxt;
   reg [PC_W-1:0] base_r;
   reg [PC_W-1:0] base_nxt;

   // next values of the registered outputs
   reg pc_we_nxt;
   reg [PC_W-1:0] pc_new_nxt;
   reg busy_nxt;
   reg done_nxt;

   // decode condition and single-cycle events that steer the sequencer and its outputs
   wire q1_end;
   wire q3_end;
   wire q4_end;
   wire decode_hit;
   wire start_exec;
   wire exec_q3;
   wire exec_q4;
   wire stall_q4;

   quarter_phase_gen #(.DIV(DIV)) u_qgen (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .q_en_r(q_en),
      .q_phase_r(q_phase)
   );

   // true when the upper opcode byte selects the overflow branch
   function is_ovf_branch;
      input [15:0] word;
      begin
         is_ovf_branch = (word[`BOVF_OPC_MSB:`BOVF_OPC_LSB] == `BOVF_OPCODE_HI);
      end
   endfunction

   // true in the clock cycle that closes the given quarter
   function quarter_end;
      input en;
      input [1:0] phase;
      input [1:0] which;
      begin
         quarter_end = en && (phase == which);
      end
   endfunction

   // sign extend and double the 8-bit offset
   function [PC_W-1:0] dbl_ofs;
      input [7:0] n;
      begin
         dbl_ofs = {{(PC_W-9){n[7]}}, n, 1'b0}; // RQ2
      end
   endfunction

   // quarter ends; the divider numbers the quarter that is closing
   assign q1_end = quarter_end(q_en, q_phase, `BOVF_Q1);
   assign q3_end = quarter_end(q_en, q_phase, `BOVF_Q3);
   assign q4_end = quarter_end(q_en, q_phase, `BOVF_Q4);

   // only a valid word with the right opcode starts a branch; others pass by
   assign decode_hit = instr_valid && is_ovf_branch(instr_word); // RQ1
   assign start_exec = (state_r == S_IDLE) && q1_end && decode_hit;

   // work points inside the branch
   assign exec_q3 = (state_r == S_EXEC) && q3_end;
   assign exec_q4 = (state_r == S_EXEC) && q4_end;
   assign stall_q4 = (state_r == S_STALL) && q4_end;

   // sequencer: idle, first instruction cycle, idle second cycle of a taken branch
   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE:
         begin
            if (start_exec)
               state_nxt = S_EXEC;
         end
         S_EXEC:
         begin
            if (q4_end)
               state_nxt = take_r ? S_STALL : S_IDLE; // RQ5
         end
         S_STALL:
         begin
            if (q4_end)
               state_nxt = S_IDLE; // RQ5
         end
         default:
            state_nxt = S_IDLE;
      endcase
   end

   // decode capture: word, flag and counter are only trusted at the Q1 end
   always @*
   begin
      take_nxt = take_r;
      ofs_nxt = ofs_r;
      base_nxt = base_r;
      if (start_exec)
      begin
         // status flags are only read here, never written
         take_nxt = ovf_flag; // RQ1
         ofs_nxt = instr_word[`BOVF_OFS_MSB:`BOVF_OFS_LSB]; // RQ2
         base_nxt = pc_incr; // RQ4
      end
   end

   // output next values; the target is formed in Q3 ahead of the Q4 write
   always @*
   begin
      pc_we_nxt = 1'b0;
      done_nxt = 1'b0;
      pc_new_nxt = pc_new_r;
      busy_nxt = (state_nxt != S_IDLE);
      if (exec_q3)
         pc_new_nxt = base_r + dbl_ofs(ofs_r); // RQ3
      if (exec_q4)
      begin
         pc_we_nxt = take_r; // RQ5
         done_nxt = ~take_r; // RQ5
      end
      if (stall_q4)
         done_nxt = 1'b1; // RQ5
   end

   // sequencer register
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         state_r <= S_IDLE;
      else
         state_r <= state_nxt;
   end

   // decode registers
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         take_r <= 1'b0;
         ofs_r <= 8'h00;
         base_r <= `BOVF_PC_RESET;
      end
      else
      begin
         take_r <= take_nxt;
         ofs_r <= ofs_nxt;
         base_r <= base_nxt;
      end
   end

   // control outputs
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pc_we_r <= 1'b0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         pc_we_r <= pc_we_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
      end
   end

   // branch target; held between branches
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         pc_new_r <= `BOVF_PC_RESET;
      else
         pc_new_r <= pc_new_nxt;
   end

   // quarter number for whoever watches the core timing, one clock late
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         q_phase_out_r <= `BOVF_PHASE_RESET;
      else
         q_phase_out_r <= q_phase;
   end
endmodule // branch_on_overflow

/* File: sim/branch_on_overflow_properties.sv */
`timescale 1ns/1ps
module branch_checker #(parameter PC_W=21)(input wire ref_clk,input wire rstn,input wire instr_valid,
input wire [15:0] instr_word,input wire [PC_W-1:0] pc_incr,input wire ovf_flag,input wire pc_we_r,
input wire [PC_W-1:0] pc_new_r,input wire busy_r,input wire done_r,input wire [1:0] q_phase_out_r);
default clocking @(posedge ref_clk); endclocking
default disable iff (!rstn);
a_taken_on_ovf: assert property (pc_we_r |-> $past(ovf_flag,13) && $past(instr_word[15:8],13)==8'he4)
   else $error("write without overflow");
a_offset_doubled: assert property (pc_we_r |-> pc_new_r[0]==$past(pc_incr[0],13))
   else $error("odd target");
a_target_sum: assert property (pc_we_r |-> pc_new_r==$past(pc_incr,13)+
   {{(PC_W-9){$past(instr_word[7],13)}},$past(instr_word[7:0],13),1'b0}) else $error("bad target");
a_phase_at_end: assert property ((pc_we_r || done_r) |-> q_phase_out_r==2'h3)
   else $error("end outside last quarter");
a_two_cycles: assert property (pc_we_r |-> busy_r && !done_r ##16 done_r && !busy_r)
   else $error("bad length");
a_end_in_cycle: assert property ($rose(busy_r) |-> ##[11:13] (pc_we_r ^ done_r))
   else $error("no end");
cover property (pc_we_r);
cover property ($rose(busy_r) ##12 done_r);
cover property ($rose(busy_r) && !ovf_flag);
endmodule // branch_checker
bind branch_on_overflow branch_checker #(.PC_W(PC_W)) i_chk(.ref_clk(ref_clk),.rstn(rstn),
.instr_valid(instr_valid),.instr_word(instr_word),.pc_incr(pc_incr),.ovf_flag(ovf_flag),.pc_we_r(pc_we_r),
.pc_new_r(pc_new_r),.busy_r(busy_r),.done_r(done_r),.q_phase_out_r(q_phase_out_r));

/* File: sim/pc_model.sv */
`timescale 1ns/1ps
module pc_model(input wire ref_clk,input wire rstn,input wire pc_we_r,input wire [20:0] pc_new_r,
input wire done_r,output wire [20:0] pc_incr);
reg [20:0] pc_r;
assign pc_incr = pc_r+21'h000002;
always @(posedge ref_clk or negedge rstn)
   if (!rstn) pc_r <= 21'h000100;
   else if (pc_we_r) pc_r <= pc_new_r-21'h000002;
   else if (done_r) pc_r <= pc_r+21'h000002;
endmodule // pc_model

/* File: sim/branch_on_overflow_tb.sv */
`timescale 1ns/1ps
module branch_on_overflow_tb;
reg ref_clk=0,rstn=0,instr_valid=0,ovf_flag=0,we_seen=0;
reg [15:0] instr_word=16'h0000;
reg [31:0] rnd=32'he4f9033a;
reg [21:0] e;
reg [21:0] expq[$];
wire pc_we_r,busy_r,done_r;
wire [20:0] pc_new_r,pc_incr;
int miscompares=0,num_checks=0,i,k;
initial forever #12.5 ref_clk=~ref_clk;
branch_on_overflow i_dut(.ref_clk(ref_clk),.rstn(rstn),.instr_valid(instr_valid),.instr_word(instr_word),
.pc_incr(pc_incr),.ovf_flag(ovf_flag),.pc_we_r(pc_we_r),.pc_new_r(pc_new_r),.busy_r(busy_r),.done_r(done_r),
.q_phase_out_r());
pc_model i_pc(.ref_clk(ref_clk),.rstn(rstn),.pc_we_r(pc_we_r),.pc_new_r(pc_new_r),.done_r(done_r),.pc_incr(pc_incr));
task stop_test;
   $display("checks %0d bad %0d",num_checks,miscompares);
   if (miscompares==0 && num_checks>0) $display("STATUS OK");
   else $display("STATUS NOT OK");
   $finish;
endtask
function [31:0] xorshift(input [31:0] s);
   reg [31:0] t;
   begin
      t = s^(s<<13);
      t = t^(t>>17);
      xorshift = t^(t<<5);
   end
endfunction
always @(posedge ref_clk)
begin
   if (pc_we_r) we_seen = 1'b1;
   if (done_r && expq.size()==0)
   begin
      num_checks++;
      miscompares++;
      $display("BAD %0t %h %h",$time,22'h0,{we_seen,pc_new_r});
      we_seen = 1'b0;
   end
   else if (done_r)
   begin
      e = expq.pop_front();
      num_checks++;
      if (e !== {we_seen,we_seen ? pc_new_r : 21'h0})
         $display("BAD %0t %h %h",$time,e,{we_seen,pc_new_r});
      if (e !== {we_seen,we_seen ? pc_new_r : 21'h0}) miscompares++;
      we_seen = 1'b0;
   end
end
initial
begin
   repeat (20) @(posedge ref_clk);
   #2 rstn = 1;
   instr_valid = 1;
   for (i=0; i<12; i++)
   begin
      // one edge lets the counter model take the last done before the base is read
      @(posedge ref_clk);
      #2 rnd = xorshift(rnd);
      instr_word = {i==5 ? 8'he0 : 8'he4, i==0 ? 8'h80 : i==1 ? 8'h7f : rnd[7:0]};
      ovf_flag = i<2 || rnd[9];
      #1 if (i!=5) expq.push_back(ovf_flag ? {1'b1,pc_incr+{{12{instr_word[7]}},instr_word[7:0],1'b0}} : 22'h0);
      k = 0;
      while (k<80 && !done_r)
      begin
         @(posedge ref_clk);
         #2 k++;
      end
      if (i!=5 && k==80) miscompares++;
      if (i!=5 && k==80) stop_test();
      $display("test %0d done",i);
   end
   stop_test();
end
endmodule // branch_on_overflow_tb
